// ---- smsre_pkg.sv ----
package smsre_pkg;

  // Register map
  localparam logic [15:0] ADDR_UART_MODE  = 16'hFF70;
  localparam logic [15:0] ADDR_RX_ERR     = 16'hFF71;
  localparam logic [15:0] ADDR_CS_MODE    = 16'hFF72;
  localparam logic [15:0] ADDR_BAUD       = 16'hFF73;
  localparam logic [15:0] ADDR_DATA       = 16'hFF74;
  localparam logic [15:0] ADDR_PORT_OUT   = 16'hFF75;
  localparam logic [15:0] ADDR_PORT_DIR   = 16'hFF76;
  localparam logic [15:0] ADDR_PORT_PIN   = 16'hFF77;
  localparam logic [15:0] ADDR_INT_STATUS = 16'hFF78;
  localparam logic [15:0] ADDR_INT_CLEAR  = 16'hFF79;
  localparam logic [15:0] ADDR_INT_ENABLE = 16'hFF7A;

  // Field positions, and the interrupt field width
  localparam int UM_TX_EN   = 7;
  localparam int UM_RX_EN   = 6;
  localparam int UM_PAR_HI  = 5;
  localparam int UM_PAR_LO  = 4;
  localparam int UM_CHAR8   = 3;
  localparam int UM_STOP2   = 2;
  localparam int CS_EN      = 7;
  localparam int CS_DIR     = 2;
  localparam int CS_SRC     = 1;
  localparam int BAUD_HI    = 7;
  localparam int BAUD_LO    = 4;
  localparam int ERR_PE     = 2;
  localparam int ERR_FE     = 1;
  localparam int ERR_OV     = 0;
  localparam int INT_RX     = 0;
  localparam int INT_TX     = 1;
  localparam int INT_PE     = 2;
  localparam int INT_FE     = 3;
  localparam int INT_OV     = 4;
  localparam int INT_W      = 5;
  localparam int PIN_CLK    = 0;
  localparam int PIN_TX     = 1;
  localparam int PIN_RX     = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [2:0] RST_PORT_DIR = 3'h7;

  // Counts in ticks or bits, and the baud select code for the external clock
  localparam logic [3:0] TICK_LAST  = 4'hF;
  localparam logic [3:0] TICK_HALF  = 4'h7;
  localparam logic [3:0] SHIFT_LAST = 4'h7;
  localparam logic [3:0] BAUD_EXT   = 4'h8;

  typedef enum logic [1:0] {
    SMSRE_PAR_NONE,
    SMSRE_PAR_ZERO,
    SMSRE_PAR_ODD,
    SMSRE_PAR_EVEN
  } smsre_par_t;

  // Parity bit to send, or to expect, for a character
  function automatic logic smsre_par_bit(input logic [7:0] d, input logic char8,
                                         input smsre_par_t p);
    logic ones;
    ones = char8 ? ^d : ^d[6:0];
    case (p)
      SMSRE_PAR_ODD:  return ~ones;
      SMSRE_PAR_EVEN: return ones;
      default:        return 1'b0;
    endcase
  endfunction

endpackage

// ---- smsre_uart_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsre_uart_rx (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  // Control
  input  wire logic              enable_i,
  input  wire logic              tick_i,
  input  wire logic              char8_i,
  input  wire smsre_pkg::smsre_par_t par_i,
  // Serial line, already synchronised
  input  wire logic              rxd_i,
  // Completed frame
  output logic                   done_o,
  output logic [7:0]             data_o,
  output logic                   parity_err_o,
  output logic                   framing_err_o
);
  import smsre_pkg::*;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} smsre_rx_st_t;

  typedef struct packed {
    smsre_rx_st_t st;
    logic [3:0]   sub;
    logic [2:0]   idx;
    logic [7:0]   data;
    logic         par;
    logic         done;
    logic         pe;
    logic         fe;
  } smsre_rx_t;

  smsre_rx_t cur;
  smsre_rx_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (!enable_i) begin
      next_cur.st = RX_IDLE;
    end else if (tick_i) begin
      next_cur.sub = cur.sub + 4'h1;
      case (cur.st)
        RX_IDLE: begin
          if (!rxd_i) begin
            next_cur.st  = RX_START;
            next_cur.sub = 4'h0;
          end
        end
        RX_START: begin
          // Glitch shorter than half a bit is dropped
          if (cur.sub == TICK_HALF) begin
            next_cur.sub  = 4'h0;
            next_cur.idx  = 3'h0;
            next_cur.data = 8'h00;
            next_cur.st   = rxd_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (cur.sub == TICK_LAST) begin
            next_cur.data[cur.idx] = rxd_i;
            next_cur.idx = cur.idx + 3'h1;
            if (cur.idx == (char8_i ? 3'h7 : 3'h6)) begin
              next_cur.st = (par_i == SMSRE_PAR_NONE) ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (cur.sub == TICK_LAST) begin
            next_cur.par = rxd_i;
            next_cur.st  = RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is looked at
          if (cur.sub == TICK_LAST) begin
            next_cur.done = 1'b1;
            next_cur.fe   = ~rxd_i;
            next_cur.pe   = par_i[1] &&
                            (cur.par != smsre_par_bit(cur.data, char8_i, par_i));
            next_cur.st   = RX_IDLE;
          end
        end
        default: next_cur.st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done_o        = cur.done;
  assign data_o        = cur.data;
  assign parity_err_o  = cur.pe;
  assign framing_err_o = cur.fe;

endmodule // smsre_uart_rx
`default_nettype wire

// ---- smsre_serial.sv ----
// Notes on behaviour
// - With all three enables clear, no transfer; the three pins are plain port pins.
// - Clocked mode: UART enables 0, clocked enable 1; order and clock source selectable.
// - Clocked mode drives the data output; data input may stay a port pin.
// - UART mode: clocked, order, source controls 0; LSB first; enables pick direction.
// - UART pins take their function only when the matching enable or source is chosen.
// - Error status reports receive errors in UART mode only; undefined in clocked mode.
// - Reset clears the receive error status to zero.
// - Error status is read-only; bits seven to three read zero.
// - Parity error flag set on mismatch; never when parity checking is off.
// - Framing error flag set when the stop bit is missing.
// - Only the first stop bit is checked on receive.
// - Overrun flag set when a frame completes before the buffer was read.
// - Until the buffer is read, every further frame flags overrun again.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module smsre_serial (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  // Interrupt
  output logic            irq_o,
  // Pins: bit 0 clock, bit 1 data out, bit 2 data in
  input  wire logic [2:0] port_pin_i,
  output logic [2:0]      port_pin_o,
  output logic [2:0]      port_pin_oe_n_o
);
  import smsre_pkg::*;

  typedef struct packed {
    logic             tx_en;
    logic             rx_en;
    smsre_par_t       par;
    logic             char8;
    logic             stop2;
    logic             cs_en;
    logic             bit_order;
    logic             clk_src;
    logic [3:0]       baud_sel;
    logic [2:0]       port_out;
    logic [2:0]       port_dir;
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic [2:0]       sync3;
    logic [2:0]       err;
    logic [INT_W-1:0] int_sts;
    logic [INT_W-1:0] int_en;
    logic [7:0]       rx_buf;
    logic             unread;
    logic [7:0]       rdata;
    logic             irq;
    logic [7:0]       baud_cnt;
    logic [11:0]      tx_sh;
    logic [3:0]       tx_cnt;
    logic [3:0]       tx_sub;
    logic             tx_busy;
    logic [7:0]       sh;
    logic [3:0]       sh_cnt;
    logic             sh_busy;
    logic             sh_in;
    logic             sck;
    logic [2:0]       pin_o;
    logic [2:0]       pin_oe_n;
  } smsre_state_t;

  smsre_state_t cur;
  smsre_state_t next_cur;

  logic       mode_stop;
  logic       mode_three;
  logic       mode_uart;
  logic       ext_baud;
  logic [3:0] baud_n;
  logic [7:0] baud_limit;
  logic       tick;
  logic       clk_rise;
  logic       clk_fall;
  logic       sck_rise;
  logic       sck_fall;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_pe;
  logic       rx_fe;

  // Shift one bit into the clocked-mode register in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb_first);
    return lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // Any combination outside the three legal ones falls back to stop
  assign mode_three = cur.cs_en && !cur.tx_en && !cur.rx_en;
  assign mode_uart  = !cur.cs_en && !cur.bit_order && !cur.clk_src &&
                      (cur.tx_en || cur.rx_en);
  assign mode_stop  = !mode_three && !mode_uart;
  assign ext_baud   = (cur.baud_sel == BAUD_EXT);

  // Internal tick every 2^(sel+1) clocks, sixteen ticks to a UART bit, two to a clocked bit
  assign baud_n     = cur.baud_sel + 4'h1;
  assign baud_limit = 8'((9'h001 << baud_n) - 9'h001);
  assign clk_rise   = cur.sync2[PIN_CLK] && !cur.sync3[PIN_CLK];
  assign clk_fall   = !cur.sync2[PIN_CLK] && cur.sync3[PIN_CLK];
  assign tick       = mode_stop ? 1'b0 :
                      ext_baud ? (mode_uart && clk_rise) :
                      (cur.baud_sel < BAUD_EXT) && (cur.baud_cnt == baud_limit);

  // Shift clock edges: internal toggle or the synced pin
  assign sck_rise = cur.sh_busy && (cur.clk_src ? (tick && !cur.sck) : clk_rise);
  assign sck_fall = cur.sh_busy && (cur.clk_src ? (tick && cur.sck) : clk_fall);

  smsre_uart_rx u_rx (
    .clock_i       (clock_i),
    .reset_n_i     (reset_n_i),
    .enable_i      (mode_uart && cur.rx_en),
    .tick_i        (tick),
    .char8_i       (cur.char8),
    .par_i         (cur.par),
    .rxd_i         (cur.sync2[PIN_RX]),
    .done_o        (rx_done),
    .data_o        (rx_data),
    .parity_err_o  (rx_pe),
    .framing_err_o (rx_fe)
  );

  always_comb begin
    logic [11:0] frame;
    logic [3:0]  flen;
    logic        tx_evt;
    logic        sh_evt;
    logic [7:0]  sh_done;
    frame    = 12'hFFF;
    flen     = 4'h0;
    tx_evt   = 1'b0;
    sh_evt   = 1'b0;
    sh_done  = 8'h00;
    next_cur = cur;

    next_cur.sync1 = port_pin_i;
    next_cur.sync2 = cur.sync1;
    next_cur.sync3 = cur.sync2;

    // Register reads, one cycle latency
    next_cur.rdata = RST_BYTE;
    if (rd_i) begin
      case (addr_i)
        ADDR_UART_MODE:  next_cur.rdata = {cur.tx_en, cur.rx_en, cur.par, cur.char8,
                                           cur.stop2, 2'h0};
        ADDR_RX_ERR: begin
          next_cur.rdata = {5'h00, cur.err};
          // Read clears the status; a frame end in this cycle wins
          next_cur.err   = 3'h0;
        end
        ADDR_CS_MODE:    next_cur.rdata = {cur.cs_en, 4'h0, cur.bit_order, cur.clk_src, 1'b0};
        ADDR_BAUD:       next_cur.rdata = {cur.baud_sel, 4'h0};
        ADDR_DATA: begin
          next_cur.rdata  = cur.rx_buf;
          next_cur.unread = 1'b0;
        end
        ADDR_PORT_OUT:   next_cur.rdata = {5'h00, cur.port_out};
        ADDR_PORT_DIR:   next_cur.rdata = {5'h00, cur.port_dir};
        ADDR_PORT_PIN:   next_cur.rdata = {5'h00, cur.sync2};
        ADDR_INT_STATUS: next_cur.rdata = {3'h0, cur.int_sts};
        ADDR_INT_ENABLE: next_cur.rdata = {3'h0, cur.int_en};
        default:         next_cur.rdata = RST_BYTE;
      endcase
    end

    // Register writes; error status has no write path
    if (wr_i) begin
      case (addr_i)
        ADDR_UART_MODE: begin
          next_cur.tx_en = wdata_i[UM_TX_EN];
          next_cur.rx_en = wdata_i[UM_RX_EN];
          next_cur.par   = smsre_par_t'(wdata_i[UM_PAR_HI:UM_PAR_LO]);
          next_cur.char8 = wdata_i[UM_CHAR8];
          next_cur.stop2 = wdata_i[UM_STOP2];
        end
        ADDR_CS_MODE: begin
          next_cur.cs_en     = wdata_i[CS_EN];
          next_cur.bit_order = wdata_i[CS_DIR];
          next_cur.clk_src   = wdata_i[CS_SRC];
        end
        ADDR_BAUD: next_cur.baud_sel = wdata_i[BAUD_HI:BAUD_LO];
        ADDR_DATA: begin
          if (mode_uart && cur.tx_en && !cur.tx_busy) begin
            // Frame goes out LSB first: start, data, parity, stops
            frame[0]   = 1'b0;
            frame[8:1] = cur.char8 ? wdata_i : {1'b1, wdata_i[6:0]};
            if (cur.par != SMSRE_PAR_NONE) begin
              frame[cur.char8 ? 9 : 8] = smsre_par_bit(wdata_i, cur.char8, cur.par);
            end
            flen = 4'h1 + (cur.char8 ? 4'h8 : 4'h7) +
                   ((cur.par != SMSRE_PAR_NONE) ? 4'h1 : 4'h0) +
                   (cur.stop2 ? 4'h2 : 4'h1);
            next_cur.tx_sh   = frame;
            next_cur.tx_cnt  = flen;
            next_cur.tx_sub  = 4'h0;
            next_cur.tx_busy = 1'b1;
          end else if (mode_three && !cur.sh_busy) begin
            next_cur.sh      = wdata_i;
            next_cur.sh_cnt  = 4'h0;
            next_cur.sh_busy = 1'b1;
          end
        end
        ADDR_PORT_OUT:   next_cur.port_out = wdata_i[2:0];
        ADDR_PORT_DIR:   next_cur.port_dir = wdata_i[2:0];
        ADDR_INT_CLEAR:  next_cur.int_sts  = cur.int_sts & ~wdata_i[INT_W-1:0];
        ADDR_INT_ENABLE: next_cur.int_en   = wdata_i[INT_W-1:0];
        default: ;
      endcase
    end

    // Baud prescaler
    // A divider write in mid-frame garbles the bit in flight
    if (tick || mode_stop || ext_baud) begin
      next_cur.baud_cnt = 8'h00;
    end else begin
      next_cur.baud_cnt = cur.baud_cnt + 8'h01;
    end

    // UART transmitter
    if (!(mode_uart && cur.tx_en)) begin
      next_cur.tx_busy = 1'b0;
    end else if (cur.tx_busy && tick) begin
      next_cur.tx_sub = cur.tx_sub + 4'h1;
      if (cur.tx_sub == TICK_LAST) begin
        // Ones shift in behind the frame, so the line ends high
        next_cur.tx_sh  = {1'b1, cur.tx_sh[11:1]};
        next_cur.tx_cnt = cur.tx_cnt - 4'h1;
        if (cur.tx_cnt == 4'h1) begin
          next_cur.tx_busy = 1'b0;
          tx_evt = 1'b1;
        end
      end
    end

    // Clocked serial: sample on rising edge, shift on falling edge
    if (!mode_three) begin
      next_cur.sh_busy = 1'b0;
      next_cur.sh_cnt  = 4'h0;
      next_cur.sck     = 1'b1;
    end else if (cur.sh_busy) begin
      if (cur.clk_src && tick) begin
        next_cur.sck = ~cur.sck;
      end
      if (sck_rise) begin
        if (cur.sh_cnt == SHIFT_LAST) begin
          sh_done = shift_in(cur.sh, cur.sync2[PIN_RX], cur.bit_order);
          next_cur.sh      = sh_done;
          next_cur.sh_busy = 1'b0;
          next_cur.sh_cnt  = 4'h0;
          sh_evt = 1'b1;
        end else begin
          next_cur.sh_in  = cur.sync2[PIN_RX];
          next_cur.sh_cnt = cur.sh_cnt + 4'h1;
        end
      end
      if (sck_fall && cur.sh_cnt != 4'h0) begin
        next_cur.sh = shift_in(cur.sh, cur.sh_in, cur.bit_order);
      end
    end

    // Received byte and error flags; a new event wins over a read
    // A clocked byte always lands; only UART frames can overrun
    if (sh_evt) begin
      next_cur.rx_buf = sh_done;
      next_cur.unread = 1'b1;
    end
    if (rx_done) begin
      // Overrun keeps the unread byte in the buffer
      next_cur.err[ERR_OV] = cur.unread;
      next_cur.err[ERR_PE] = rx_pe;
      next_cur.err[ERR_FE] = rx_fe;
      if (!cur.unread) begin
        next_cur.rx_buf = rx_data;
        next_cur.unread = 1'b1;
      end
    end

    // Sticky interrupt status
    if (rx_done || sh_evt) next_cur.int_sts[INT_RX] = 1'b1;
    if (tx_evt)            next_cur.int_sts[INT_TX] = 1'b1;
    if (rx_done && rx_pe)  next_cur.int_sts[INT_PE] = 1'b1;
    if (rx_done && rx_fe)  next_cur.int_sts[INT_FE] = 1'b1;
    if (rx_done && cur.unread) next_cur.int_sts[INT_OV] = 1'b1;
    next_cur.irq = |(next_cur.int_sts & next_cur.int_en);

    // Pins default to port function; dir bit 1 means input
    next_cur.pin_o    = cur.port_out;
    next_cur.pin_oe_n = cur.port_dir;
    if (mode_three) begin
      // Data out holds its last bit while idle, so it
      // never moves together with the final rising clock
      if (cur.sh_busy) begin
        next_cur.pin_o[PIN_TX] = cur.bit_order ? cur.sh[0] : cur.sh[7];
      end else begin
        next_cur.pin_o[PIN_TX] = cur.pin_o[PIN_TX];
      end
      next_cur.pin_oe_n[PIN_TX] = 1'b0;
      next_cur.pin_o[PIN_CLK]   = cur.sck;
      next_cur.pin_oe_n[PIN_CLK] = ~cur.clk_src;
    end else if (mode_uart) begin
      if (cur.tx_en) begin
        next_cur.pin_o[PIN_TX]    = cur.tx_busy ? cur.tx_sh[0] : 1'b1;
        next_cur.pin_oe_n[PIN_TX] = 1'b0;
      end
      if (cur.rx_en) begin
        next_cur.pin_oe_n[PIN_RX] = 1'b1;
      end
      if (ext_baud) begin
        next_cur.pin_oe_n[PIN_CLK] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cur          <= '0;
      // Pins come up as inputs until software picks their roles
      cur.port_dir <= RST_PORT_DIR;
      cur.pin_oe_n <= RST_PORT_DIR;
      cur.sck      <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_o         = cur.rdata;
  assign irq_o           = cur.irq;
  assign port_pin_o      = cur.pin_o;
  assign port_pin_oe_n_o = cur.pin_oe_n;

endmodule // smsre_serial
`default_nettype wire

// ---- smsre_serial_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsre_serial_asserts
  import smsre_pkg::*;
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // Pins
  input wire logic [2:0]  port_pin_o,
  input wire logic [2:0]  port_pin_oe_n_o
);
  logic [7:0] um;
  logic [7:0] cs;
  logic [7:0] baud;
  logic [2:0] dir;
  logic [2:0] pout;
  logic [1:0] quiet;
  logic [2:0] since_rst;
  logic       stop_m;
  logic       clk_m;
  logic       uart_m;
  logic       ext;

  // Shadow of the mode registers, so pin roles can be predicted
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      um        <= RST_BYTE;
      cs        <= RST_BYTE;
      baud      <= RST_BYTE;
      dir       <= RST_PORT_DIR;
      pout      <= 3'h0;
      quiet     <= 2'h0;
      since_rst <= 3'h0;
    end else begin
      if (wr_i && addr_i == ADDR_UART_MODE) um <= wdata_i;
      if (wr_i && addr_i == ADDR_CS_MODE) cs <= wdata_i;
      if (wr_i && addr_i == ADDR_BAUD) baud <= wdata_i;
      if (wr_i && addr_i == ADDR_PORT_DIR) dir <= wdata_i[2:0];
      if (wr_i && addr_i == ADDR_PORT_OUT) pout <= wdata_i[2:0];
      quiet     <= wr_i ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
      since_rst <= (since_rst == 3'h7) ? since_rst : since_rst + 3'h1;
    end
  end

  assign stop_m = um[UM_TX_EN:UM_RX_EN] == 2'h0 && !cs[CS_EN];
  assign clk_m  = um[UM_TX_EN:UM_RX_EN] == 2'h0 && cs[CS_EN];
  assign uart_m = um[UM_TX_EN:UM_RX_EN] != 2'h0 && cs[CS_EN:CS_EN] == 1'b0
                  && !cs[CS_DIR] && !cs[CS_SRC];
  assign ext    = baud[BAUD_HI:BAUD_LO] == BAUD_EXT;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_err_read;
    rd_i && addr_i == ADDR_RX_ERR;
  endsequence
  sequence s_settled;
    quiet == 2'h3;
  endsequence

  a_reset_status: assert property (
    since_rst < 3'h4 && rd_i && addr_i == ADDR_RX_ERR |=> rdata_o == RST_BYTE)
    else $error("status not zero after reset");
  a_upper_zero: assert property (s_err_read |=> rdata_o[7:3] == 5'h00)
    else $error("status upper bits not zero");
  a_stop_port: assert property (s_settled ##0 stop_m |->
    port_pin_oe_n_o == dir && (port_pin_o & ~dir) == (pout & ~dir))
    else $error("stop mode pins not port pins");
  a_clk_data_out: assert property (s_settled ##0 clk_m |-> !port_pin_oe_n_o[PIN_TX])
    else $error("clocked data out not driven");
  a_clk_source: assert property ((quiet == 2'h3 && clk_m)[*2] |->
    port_pin_oe_n_o[PIN_CLK] == !cs[CS_SRC])
    else $error("shift clock direction wrong");
  a_tx_pin: assert property (s_settled ##0 uart_m |->
    port_pin_oe_n_o[PIN_TX] == (um[UM_TX_EN] ? 1'b0 : dir[PIN_TX]))
    else $error("transmit pin role wrong");
  a_baud_in: assert property (s_settled ##0 (uart_m && ext) |->
    port_pin_oe_n_o[PIN_CLK] && $stable(port_pin_oe_n_o[PIN_CLK]))
    else $error("baud clock pin not input");
  a_baud_port: assert property (s_settled ##0 (uart_m && !ext) |->
    port_pin_oe_n_o[PIN_CLK] == dir[PIN_CLK])
    else $error("baud pin not port pin");
endmodule // smsre_serial_asserts

bind smsre_serial smsre_serial_asserts i_smsre_serial_asserts (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_pin_o(port_pin_o),
  .port_pin_oe_n_o(port_pin_oe_n_o));
`default_nettype wire

// ---- smsre_link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsre_link_partner (
  // Link towards the block
  output logic baud_clk_o,
  output logic rxd_o
);
  initial begin
    baud_clk_o = 1'b0;
    rxd_o      = 1'b1;
  end

  // One bit is 16 baud clock periods; clock stands still except while a bit or a gap is sent
  task automatic bit_out(input logic v);
    rxd_o = v;
    repeat (16) begin
      #400 baud_clk_o = 1'b1;
      #400 baud_clk_o = 1'b0;
    end
  endtask

  // Odd offset keeps link edges clear of system clock edges
  task automatic send(input logic [7:0] d, input logic has_par, input logic pbit,
                      input logic stop);
    #37;
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(d[i]);
    end
    if (has_par) begin
      bit_out(pbit);
    end
    bit_out(stop);
    rxd_o = 1'b1;
  endtask

  task automatic gap();
    bit_out(1'b1);
  endtask
endmodule // smsre_link_partner
`default_nettype wire

// ---- smsre_serial_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsre_serial_bench;
  import smsre_pkg::*;
  logic        clock_i;
  logic        reset_n_i;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        irq_o;
  logic [2:0]  port_pin_i;
  logic [2:0]  port_pin_o;
  logic [2:0]  port_pin_oe_n_o;
  logic        lk_clk;
  logic        lk_rxd;
  int          failures;
  int          n_tests;
  logic [7:0]  um_t[7] = '{8'h80, 8'h40, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cs_t[7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h82, 8'h86, 8'h84};
  logic [2:0]  oe_t[7] = '{3'h5, 3'h7, 3'h5, 3'h5, 3'h4, 3'h4, 3'h5};

  smsre_serial i_smsre_serial (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
    .port_pin_oe_n_o(port_pin_oe_n_o));
  smsre_link_partner i_smsre_link_partner (.baud_clk_o(lk_clk), .rxd_o(lk_rxd));

  // Pin levels; the transmit line has a pull-up
  always_comb begin
    port_pin_i[PIN_CLK] = port_pin_oe_n_o[PIN_CLK] ? lk_clk : port_pin_o[PIN_CLK];
    port_pin_i[PIN_TX]  = port_pin_oe_n_o[PIN_TX] ? 1'b1 : port_pin_o[PIN_TX];
    port_pin_i[PIN_RX]  = port_pin_oe_n_o[PIN_RX] ? lk_rxd : port_pin_o[PIN_RX];
  end

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask

  task automatic rx_frame(input logic [7:0] um, input logic [7:0] d, input logic par,
                          input logic pbit, input logic stop, input logic [7:0] st);
    wr(ADDR_UART_MODE, um);
    i_smsre_link_partner.send(d, par, pbit, stop);
    i_smsre_link_partner.gap();
    rdc(ADDR_RX_ERR, st);
    rdc(ADDR_DATA, d);
  endtask

  task automatic t_stop_port();
    wr(ADDR_PORT_DIR, 8'h00);
    wr(ADDR_PORT_OUT, 8'h05);
    repeat (3) @(posedge clock_i);
    chk({5'h00, port_pin_oe_n_o}, 8'h00);
    chk({5'h00, port_pin_o}, 8'h05);
    rdc(ADDR_PORT_PIN, 8'h05);
    wr(ADDR_PORT_DIR, 8'h07);
  endtask

  task automatic t_roles();
    wr(ADDR_BAUD, 8'h80);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_UART_MODE, um_t[i]);
      wr(ADDR_CS_MODE, cs_t[i]);
      repeat (3) @(posedge clock_i);
      chk({5'h00, port_pin_oe_n_o}, {5'h00, oe_t[i]});
      wr(ADDR_UART_MODE, 8'h00);
      wr(ADDR_CS_MODE, 8'h00);
    end
  endtask

  task automatic t_overrun();
    wr(ADDR_UART_MODE, 8'h4C);
    i_smsre_link_partner.send(8'h11, 1'b0, 1'b0, 1'b1);
    i_smsre_link_partner.send(8'h22, 1'b0, 1'b0, 1'b1);
    i_smsre_link_partner.gap();
    rdc(ADDR_RX_ERR, 8'h01);
    i_smsre_link_partner.send(8'h33, 1'b0, 1'b0, 1'b1);
    i_smsre_link_partner.gap();
    rdc(ADDR_RX_ERR, 8'h01);
    rdc(ADDR_DATA, 8'h11);
    i_smsre_link_partner.send(8'h44, 1'b0, 1'b0, 1'b1);
    i_smsre_link_partner.gap();
    rdc(ADDR_RX_ERR, 8'h00);
    rdc(ADDR_DATA, 8'h44);
  endtask

  task automatic t_irq();
    wr(ADDR_INT_ENABLE, 8'h01 << INT_PE);
    rx_frame(8'h78, 8'hA5, 1'b1, ~^8'hA5, 1'b1, 8'h04);
    chk({7'h00, irq_o}, 8'h01);
    wr(ADDR_INT_CLEAR, 8'h1F);
    repeat (2) @(posedge clock_i);
    chk({7'h00, irq_o}, 8'h00);
    wr(ADDR_INT_ENABLE, 8'h00);
    rx_frame(8'h78, 8'hA5, 1'b1, ~^8'hA5, 1'b1, 8'h04);
    chk({7'h00, irq_o}, 8'h00);
    wr(ADDR_INT_ENABLE, 8'h01 << INT_PE);
    repeat (2) @(posedge clock_i);
    chk({7'h00, irq_o}, 8'h01);
    wr(ADDR_INT_CLEAR, 8'h1F);
    repeat (2) @(posedge clock_i);
    chk({7'h00, irq_o}, 8'h00);
  endtask

  // Internal shift clock; data out taken at each rise of the clock pin
  task automatic t_shift(input logic [7:0] cs, input logic [7:0] exp);
    logic [7:0] got;
    logic       prev;
    got  = 8'h00;
    prev = 1'b1;
    wr(ADDR_UART_MODE, 8'h00);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_CS_MODE, cs);
    wr(ADDR_DATA, 8'h1E);
    repeat (100) begin
      @(negedge clock_i);
      if (port_pin_o[PIN_CLK] && !prev) got = {got[6:0], port_pin_o[PIN_TX]};
      prev = port_pin_o[PIN_CLK];
    end
    chk(got, exp);
    rdc(ADDR_DATA, 8'hFF);
  endtask

  // Reset in mid-run with a framing error still pending
  task automatic t_mid_reset();
    wr(ADDR_CS_MODE, 8'h00);
    wr(ADDR_BAUD, 8'h80);
    wr(ADDR_UART_MODE, 8'h48);
    i_smsre_link_partner.send(8'h96, 1'b0, 1'b0, 1'b0);
    i_smsre_link_partner.gap();
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rdc(ADDR_RX_ERR, RST_BYTE);
    chk({5'h00, port_pin_oe_n_o}, 8'h07);
  endtask

  initial begin
    // Hangs are cut short here
    repeat (100000) @(posedge clock_i);
    failures++;
    end_sim();
  end

  initial begin
    reset_n_i = 1'b0;
    addr_i    = 16'h0000;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    failures  = 0;
    n_tests   = 0;
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rdc(ADDR_RX_ERR, RST_BYTE);
    chk({5'h00, port_pin_oe_n_o}, 8'h07);
    t_stop_port();
    t_roles();
    rx_frame(8'h78, 8'hA5, 1'b1, ^8'hA5, 1'b1, 8'h00);
    rx_frame(8'h68, 8'h3C, 1'b1, ~^8'h3C, 1'b1, 8'h00);
    rx_frame(8'h68, 8'h3C, 1'b1, ^8'h3C, 1'b1, 8'h04);
    rx_frame(8'h58, 8'h5A, 1'b1, 1'b1, 1'b1, 8'h00);
    rx_frame(8'h48, 8'hC3, 1'b0, 1'b0, 1'b0, 8'h02);
    t_overrun();
    wr(ADDR_RX_ERR, 8'hFF);
    rdc(ADDR_RX_ERR, 8'h00);
    wr(16'hFF7F, 8'hFF);
    rdc(16'hFF7F, 8'h00);
    t_irq();
    t_shift(8'h82, 8'h1E);
    t_shift(8'h86, 8'h78);
    t_mid_reset();
    end_sim();
  end
endmodule // smsre_serial_bench
`default_nettype wire
